// file: rtl/ssfe_engine.sv
// Purpose: frame engine of a synchronous serial port, SPI and pulse-framed
// Assumes: pins pass through the synchronisers below; half period >= 3 clocks
// Notes: rx words are dropped when the receive FIFO is full in slave role
`timescale 1ns/1ps
`default_nettype none
module ssfe_engine (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic enable_i,
  input wire logic master_i,
  input wire ssfe_pkg::ssfe_fmt_t frame_fmt_i,
  input wire logic clock_polarity_bit_i,
  input wire logic clock_phase_bit_i,
  input wire logic [3:0] data_size_i,
  input wire logic [7:0] prescale_divisor_i,
  input wire logic [7:0] rate_factor_i,
  input wire logic [ssfe_pkg::WORD_W-1:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  output logic [ssfe_pkg::WORD_W-1:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe_o,
  input wire logic frame_select_pin_i,
  output logic frame_select_pin_o,
  output logic frame_select_pin_oe_o,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  input wire logic serial_in_pin_i,
  output logic busy_o
);
  import ssfe_pkg::*;

  typedef struct packed {
    ssfe_state_t st;
    logic [DIV_W-1:0] div;
    logic [TGL_W-1:0] tgl;
    logic [1:0] tail;
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] tx_sh;
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] rx_hold;
    logic pend;
    logic [3:0] rx_lvl;
    logic sclk;
    logic fss;
    logic sout;
    logic soe;
    logic framed;
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic fss_m;
    logic fss_s;
    logic fss_p;
    logic sin_m;
    logic sin_s;
  } ssfe_eng_st_t;

  // =============================================================
  // helpers
  function automatic logic [CNT_W-1:0] word_len(input logic [3:0] s);
    return (s < SIZE_MIN) ? CNT_W'(SIZE_MIN) + 5'h01 : CNT_W'(s) + 5'h01;
  endfunction

  function automatic logic [DIV_W-1:0] half_len(input logic [7:0] ps, input logic [7:0] rf);
    logic [7:0] p;
    p = (ps < PRESCALE_MIN) ? PRESCALE_MIN : ps;
    return DIV_W'(p[7:1]) * (DIV_W'(rf) + 16'h0001);
  endfunction

  function automatic logic [WORD_W-1:0] low_bits(input logic [WORD_W-1:0] w,
                                                 input logic [CNT_W-1:0] n);
    return w & ((16'h0001 << n) - 16'h0001);
  endfunction

  ssfe_eng_st_t q;
  ssfe_eng_st_t d;
  logic is_spi;
  logic idle_clk;
  logic [CNT_W-1:0] nbits;
  logic tick;
  logic more;
  logic tgl_ev;
  logic lead;
  logic ld_ev;
  logic pres_ev;
  logic cap_ev;
  logic sh_ev;
  logic rx_push;
  logic [WORD_W-1:0] rx_word;
  logic tx_f_valid;
  logic [WORD_W-1:0] tx_f_data;
  logic rx_room;
  logic room2;

  // =============================================================
  // fifos
  ssfe_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(tx_f_data),
    .out_valid_o(tx_f_valid),
    .out_ready_i(ld_ev)
  );

  ssfe_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(rx_word),
    .in_valid_i(rx_push),
    .in_ready_o(rx_room),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  // =============================================================
  // frame sequencing
  always_comb begin
    d = q;
    is_spi = (frame_fmt_i == FMT_SPI);
    idle_clk = is_spi && clock_polarity_bit_i;
    nbits = word_len(data_size_i);
    more = tx_f_valid && rx_room;
    // two free slots needed when the current word is still to be pushed
    room2 = (q.rx_lvl < 4'(FIFO_DEPTH - 1));
    tick = (q.st != ST_IDLE) && (q.div == half_len(prescale_divisor_i, rate_factor_i) - 16'h0001);
    tgl_ev = 1'b0;
    lead = 1'b0;
    ld_ev = 1'b0;
    pres_ev = 1'b0;
    cap_ev = 1'b0;
    sh_ev = 1'b0;
    rx_push = 1'b0;
    rx_word = q.rx_hold;
    // two-stage synchronisers on every pin input
    d.sclk_m = serial_clock_pin_i;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.fss_m = frame_select_pin_i;
    d.fss_s = q.fss_m;
    d.fss_p = q.fss_s;
    d.sin_m = serial_in_pin_i;
    d.sin_s = q.sin_m;
    d.div = (tick || q.st == ST_IDLE) ? '0 : q.div + 16'h0001;
    if (!enable_i) begin
      d.st = ST_IDLE;
      d.sclk = idle_clk;
      d.fss = is_spi;
      d.sout = 1'b0;
      d.soe = is_spi;
      d.framed = 1'b0;
      d.pend = 1'b0;
      d.cnt = '0;
    end else if (master_i) begin
      unique case (q.st)
        ST_IDLE: begin
          d.sclk = idle_clk;
          d.fss = is_spi;
          d.sout = 1'b0;
          d.soe = is_spi;
          if (more) begin
            ld_ev = 1'b1;
            d.st = is_spi ? ST_LEAD : ST_RUN;
            d.fss = 1'b0;
            d.tgl = '0;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            d.st = ST_RUN;
            if (clock_phase_bit_i) begin
              tgl_ev = 1'b1;
            end else begin
              pres_ev = 1'b1;
            end
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (!is_spi && q.tgl == TGL_W'(nbits) * 6'h02 + 6'h02) begin
              rx_push = q.pend;
              if (more && (room2 || !q.pend)) begin
                ld_ev = 1'b1;
                tgl_ev = 1'b1;
              end else begin
                d.st = ST_IDLE;
                d.soe = 1'b0;
                d.fss = 1'b0;
              end
            end else begin
              tgl_ev = 1'b1;
              if (is_spi && q.tgl + 6'h01 == TGL_W'(nbits) * 6'h02) begin
                if (clock_phase_bit_i && more && room2) begin
                  ld_ev = 1'b1;
                end else begin
                  d.st = ST_TAIL;
                  d.tail = clock_phase_bit_i ? TAIL_PH1 : TAIL_PH0;
                end
              end
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            d.tail = q.tail - 2'h1;
            if (q.tail == 2'h1) begin
              d.fss = 1'b1;
              d.st = (!clock_phase_bit_i && more) ? ST_GAP : ST_IDLE;
            end
          end
        end
        ST_GAP: begin
          if (tick) begin
            if (more) begin
              ld_ev = 1'b1;
              d.fss = 1'b0;
              d.st = ST_LEAD;
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
      endcase
      if (tgl_ev) begin
        lead = (q.sclk == idle_clk);
        d.sclk = ~q.sclk;
        d.tgl = ld_ev ? (is_spi ? '0 : TGL_PULSE_ON) : q.tgl + 6'h01;
        if (!is_spi && d.tgl == TGL_PULSE_ON) begin
          d.fss = 1'b1;
        end
        if (!is_spi && d.tgl == TGL_PULSE_OFF) begin
          d.fss = 1'b0;
          d.soe = 1'b1;
        end
        if (is_spi) begin
          cap_ev = lead ^ clock_phase_bit_i;
          sh_ev = ~(lead ^ clock_phase_bit_i);
        end else begin
          cap_ev = !lead && !q.fss;
          sh_ev = lead && d.tgl != TGL_PULSE_ON;
        end
      end
    end else begin
      // slave: edges come from the synchronised pins
      d.st = ST_IDLE;
      d.sclk = idle_clk;
      d.fss = is_spi;
      d.soe = is_spi || q.framed;
      lead = (q.sclk_s != q.sclk_p) && (q.sclk_s != idle_clk);
      if (is_spi) begin
        if (q.fss_p && !q.fss_s) begin
          ld_ev = 1'b1;
          d.framed = 1'b1;
          pres_ev = !clock_phase_bit_i;
        end else if (q.fss_s) begin
          d.framed = 1'b0;
        end else if (q.framed && q.sclk_s != q.sclk_p) begin
          cap_ev = lead ^ clock_phase_bit_i;
          sh_ev = ~(lead ^ clock_phase_bit_i);
        end
      end else if (q.sclk_s != q.sclk_p) begin
        if (lead) begin
          rx_push = q.pend;
          if (q.fss_s) begin
            ld_ev = 1'b1;
            d.framed = 1'b1;
          end else begin
            sh_ev = q.framed;
          end
        end else begin
          cap_ev = q.framed && !q.fss_s;
        end
      end
    end
    if (rx_push) begin
      d.pend = 1'b0;
    end
    // capture incoming bit
    if (cap_ev && q.cnt < nbits) begin
      d.rx_sh = {q.rx_sh[WORD_W-2:0], q.sin_s};
      d.cnt = q.cnt + 5'h01;
      if (d.cnt == nbits) begin
        if (is_spi) begin
          rx_push = 1'b1;
          rx_word = low_bits(d.rx_sh, nbits);
          if (!master_i && clock_phase_bit_i) begin
            ld_ev = 1'b1;
          end
        end else begin
          d.rx_hold = low_bits(d.rx_sh, nbits);
          d.pend = 1'b1;
        end
      end
    end
    // load next word, MSB aligned
    if (ld_ev) begin
      d.tx_sh = tx_f_valid ? tx_f_data << (5'h10 - nbits) : WORD_RST;
      d.cnt = '0;
    end
    if (pres_ev) begin
      d.sout = d.tx_sh[WORD_W-1];
    end else if (sh_ev && q.cnt == '0 && !ld_ev) begin
      d.sout = q.tx_sh[WORD_W-1];
    end else if (sh_ev && q.cnt < nbits && !ld_ev) begin
      d.tx_sh = q.tx_sh << 1;
      d.sout = q.tx_sh[WORD_W-2];
    end
    // receive fill level, mirrors the rx fifo count
    d.rx_lvl = q.rx_lvl + 4'(rx_push && rx_room) - 4'(rx_valid_o && rx_ready_i);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.sclk <= SCLK_RST;
      q.fss <= FSS_RST;
      q.fss_m <= FSS_RST;
      q.fss_s <= FSS_RST;
      q.fss_p <= FSS_RST;
    end else begin
      q <= d;
    end
  end

  // =============================================================
  // pins
  assign serial_clock_pin_o = q.sclk;
  assign serial_clock_pin_oe_o = enable_i && master_i;
  assign frame_select_pin_o = q.fss;
  assign frame_select_pin_oe_o = enable_i && master_i;
  assign serial_out_pin_o = q.sout;
  assign serial_out_pin_oe_o = q.soe;
  assign busy_o = (q.st != ST_IDLE) || q.framed;

  // =============================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  logic mp;
  logic ms;
  assign mp = enable_i && master_i && frame_fmt_i == FMT_PULSE;
  assign ms = enable_i && master_i && frame_fmt_i == FMT_SPI;

  sequence s_sel_fall;
    ms && !clock_phase_bit_i && $fell(q.fss);
  endsequence
  sequence s_quiet2;
    $stable(q.sclk) ##1 $stable(q.sclk);
  endsequence

  idle_pulse_a: assert property (
    mp && $past(mp) && q.st == ST_IDLE && $past(q.st) == ST_IDLE
    |-> !q.sclk && !q.fss && !q.soe) else $error("pulse idle pins wrong");
  pulse_rise_a: assert property (
    mp && $rose(q.fss) |-> $rose(q.sclk)) else $error("frame pulse off clock rise");
  msb_out_a: assert property (
    mp && $fell(q.fss) |-> $rose(q.sclk) && q.soe && q.sout == $past(q.tx_sh[WORD_W-1]))
    else $error("msb not sent after pulse");
  push_rise_a: assert property (
    mp && rx_push |=> $rose(q.sclk) || q.st == ST_IDLE) else $error("rx push off rising edge");
  idle_level_a: assert property (
    ms && $past(ms) && $stable(clock_polarity_bit_i) && q.st == ST_IDLE
    && $past(q.st) == ST_IDLE |-> q.sclk == clock_polarity_bit_i)
    else $error("spi idle clock level wrong");
  idle_select_a: assert property (
    ms && $past(ms) && q.st == ST_IDLE && $past(q.st) == ST_IDLE
    |-> q.fss && !q.sout && q.soe) else $error("spi idle select or data wrong");
  start_drive_a: assert property (
    ms && $fell(q.fss) |-> q.soe && serial_clock_pin_oe_o) else $error("start without drive");
  lead_quiet_a: assert property (
    s_sel_fall |-> s_quiet2) else $error("clock moved before half period");
  phase_shift_a: assert property (
    ms && clock_phase_bit_i && q.st == ST_RUN && $changed(q.sout) |-> $changed(q.sclk))
    else $error("data changed off clock edge");
  push_room_a: assert property (
    enable_i && master_i && rx_push |-> rx_room) else $error("rx word pushed into full fifo");
endmodule
`default_nettype wire

// file: rtl/ssfe_pkg.sv
// Purpose: shared constants and types of the serial frame engine
// Assumes: 16-bit words, 8-entry FIFOs, one system clock
// Notes: size field holds word length minus one
package ssfe_pkg;
  // =============================================================
  // widths and depths
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 5;
  localparam int TGL_W = 6;
  localparam int DIV_W = 16;
  // =============================================================
  // limits and reset values
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [7:0] PRESCALE_MIN = 8'h02;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic SCLK_RST = 1'b0;
  localparam logic FSS_RST = 1'b1;
  // =============================================================
  // half periods between last clock edge and deselect
  localparam logic [1:0] TAIL_PH0 = 2'h1;
  localparam logic [1:0] TAIL_PH1 = 2'h2;
  // toggles that open and close the frame pulse
  localparam logic [TGL_W-1:0] TGL_PULSE_ON = 6'h01;
  localparam logic [TGL_W-1:0] TGL_PULSE_OFF = 6'h03;
  // =============================================================
  // types
  typedef enum logic {FMT_SPI = 1'b0, FMT_PULSE = 1'b1} ssfe_fmt_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LEAD = 5'h02,
    ST_RUN = 5'h04,
    ST_TAIL = 5'h08,
    ST_GAP = 5'h10
  } ssfe_state_t;
endpackage

// file: rtl/ssfe_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: output data is read from registered storage
`timescale 1ns/1ps
`default_nettype none
module ssfe_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ssfe_fifo_st_t;

  ssfe_fifo_st_t q;
  ssfe_fifo_st_t d;
  logic push;
  logic pop;

  // =============================================================
  // storage and pointers
  always_comb begin
    d = q;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rp];

  fill_bound_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    q.cnt <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// file: testbench/ssfe_peer_model.sv
// Purpose: far-side serial peer of the frame engine
// Assumes: engine is master; peer word k is seed_i + k * 16'h0101
// Notes: a released data line shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module ssfe_peer_model (
  input wire logic sclk_i,
  input wire logic fss_i,
  input wire logic mosi_i,
  input wire logic cpol_i,
  input wire logic cpha_i,
  input wire logic pulse_i,
  input wire logic [3:0] size_i,
  input wire logic [15:0] seed_i,
  output logic miso_o,
  output logic [15:0] got_o,
  output int cnt_o
);
  logic [15:0] sh = 16'h0000;
  logic [15:0] cap = 16'h0000;
  logic act = 1'b0;
  int bn = 0;
  initial begin
    miso_o = 1'b0;
    got_o = 16'h0000;
    cnt_o = 0;
  end
  task automatic load();
    sh = seed_i + 16'(cnt_o * 16'h0101);
    bn = int'(size_i);
  endtask
  task automatic capture();
    cap = {cap[14:0], mosi_i};
    if (bn == 0) begin
      got_o = cap & ((16'h0002 << size_i) - 16'h0001);
      cnt_o++;
      if (cpha_i && !pulse_i) load();
      else act = 1'b0;
    end else bn--;
  endtask
  // ==========
  // select edges in spi format
  always @(fss_i) begin
    if (!pulse_i && !fss_i) begin
      act = 1'b1;
      load();
      if (!cpha_i) miso_o = sh[bn];
    end else if (!pulse_i) begin
      act = 1'b0;
      miso_o = ~miso_o;
    end
  end
  // ==========
  // clock edges
  always @(sclk_i) begin
    #1;
    if (pulse_i) begin
      if (sclk_i && fss_i) begin
        act = 1'b1;
        load();
      end else if (sclk_i && act) miso_o = sh[bn];
      else if (sclk_i) miso_o = ~miso_o;
      else if (act && !fss_i) capture();
    end else if (act && !fss_i) begin
      if ((sclk_i != cpol_i) != cpha_i) capture();
      else miso_o = sh[bn];
    end
  end
endmodule
`default_nettype wire

// file: testbench/ssfe_engine_tb.sv
// Purpose: self-checking bench of the serial frame engine as master
// Assumes: peer model on the far side; rx FIFO left full to stall the master
// Notes: each run fills the tx FIFO until it refuses, then drains rx
`timescale 1ns/1ps
`default_nettype none
module ssfe_engine_tb;
  import ssfe_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic en = 1'b0;
  ssfe_fmt_t fmt = FMT_SPI;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [3:0] size = 4'hF;
  logic [7:0] pre = 8'h02;
  logic [7:0] rate = 8'h03;
  logic [15:0] txd = 16'h0000;
  logic txv = 1'b0;
  logic rxr = 1'b0;
  logic mst = 1'b1;
  logic [15:0] pseed = 16'h0000;
  wire tx_rdy, rx_vld, sclk, sclk_oe, fss, fss_oe, sout, sout_oe, busy, miso;
  wire [15:0] rxd;
  wire [15:0] got;
  int pcnt;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 32'h661E52ED;
  int rises = 0;
  int lead_cyc = 0;
  int hi_cyc = 0;
  int lc = 0;
  int hc = 0;
  logic meas = 1'b0;
  logic fss_q = 1'b1;
  logic sclk_q = 1'b0;
  logic [15:0] q_tx[$];
  logic [15:0] q_got[$];
  wire sclk_line = sclk_oe ? sclk : 1'b0;
  wire fss_line = fss_oe ? fss : 1'b1;
  // ==========
  // design and peer
  ssfe_engine ssfe_engine_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .enable_i(en), .master_i(mst),
    .frame_fmt_i(fmt), .clock_polarity_bit_i(cpol), .clock_phase_bit_i(cpha),
    .data_size_i(size), .prescale_divisor_i(pre), .rate_factor_i(rate),
    .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(tx_rdy), .rx_data_o(rxd),
    .rx_valid_o(rx_vld), .rx_ready_i(rxr), .serial_clock_pin_i(sclk_line),
    .serial_clock_pin_o(sclk), .serial_clock_pin_oe_o(sclk_oe),
    .frame_select_pin_i(fss_line), .frame_select_pin_o(fss),
    .frame_select_pin_oe_o(fss_oe), .serial_out_pin_o(sout),
    .serial_out_pin_oe_o(sout_oe), .serial_in_pin_i(miso), .busy_o(busy));
  ssfe_peer_model ssfe_peer_model_inst (
    .sclk_i(sclk_line), .fss_i(fss_line), .mosi_i(sout), .cpol_i(cpol), .cpha_i(cpha),
    .pulse_i(fmt == FMT_PULSE), .size_i(size), .seed_i(pseed), .miso_o(miso),
    .got_o(got), .cnt_o(pcnt));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ==========
  // select timing monitor
  always @(posedge clk_sys_i) begin
    fss_q <= fss;
    sclk_q <= sclk;
    lc <= (fss_q && !fss) ? 1 : lc + 1;
    hc <= (!fss_q && fss) ? 1 : hc + 1;
    if (fss_q && !fss) hi_cyc <= hc;
    if (!fss_q && fss) rises <= rises + 1;
    if (fss_q && !fss) meas <= 1'b1;
    else if (meas && sclk !== sclk_q) begin
      meas <= 1'b0;
      lead_cyc <= lc;
    end
  end
  always @(pcnt) begin
    #1;
    q_got.push_back(got);
  end
  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string what);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========
  // one configuration: fill, stall, drain, compare
  task automatic run(input int i);
    int h, k, j, base;
    logic full_seen;
    logic [15:0] m;
    @(posedge clk_sys_i);
    en <= 1'b0;
    fmt <= (i % 5 == 4) ? FMT_PULSE : FMT_SPI;
    cpol <= i[0];
    cpha <= i[1];
    size <= (i == 0) ? 4'h3 : (i == 1) ? 4'hF : 4'(3 + $unsigned($random(seed)) % 13);
    pre <= ($random(seed) & 1) ? 8'h04 : 8'h02;
    rate <= 8'(2 + $unsigned($random(seed)) % 3);
    pseed <= 16'($random(seed));
    repeat (2) @(posedge clk_sys_i);
    en <= 1'b1;
    h = (int'(pre) / 2) * (1 + int'(rate));
    m = (16'h0002 << size) - 16'h0001;
    q_tx.delete();
    q_got.delete();
    base = pcnt;
    full_seen = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rises = 0;
    if (fmt == FMT_PULSE) cmp({sclk, fss, sout_oe}, 16'h0000, "pulse idle");
    else cmp({sclk, fss, sout, sclk_oe, fss_oe, sout_oe}, {cpol, 5'b10111}, "spi idle");
    for (k = 0; k < 10; k++) begin
      @(posedge clk_sys_i);
      txv <= 1'b1;
      txd <= 16'($random(seed));
      @(negedge clk_sys_i);
      for (j = 0; j < 20000 && tx_rdy !== 1'b1; j++) begin
        full_seen = 1'b1;
        @(negedge clk_sys_i);
      end
      q_tx.push_back(txd);
    end
    @(posedge clk_sys_i);
    txv <= 1'b0;
    for (k = 0; k < 10; k++) begin
      for (j = 0; j < 20000 && rx_vld !== 1'b1; j++) @(negedge clk_sys_i);
      cmp({15'h0000, rx_vld}, 16'h0001, "rx valid");
      cmp(rxd, (pseed + 16'((base + k) * 16'h0101)) & m, "rx word");
      @(posedge clk_sys_i);
      rxr <= 1'b1;
      @(posedge clk_sys_i);
      rxr <= 1'b0;
      @(negedge clk_sys_i);
    end
    for (j = 0; j < 20000 && busy !== 1'b0; j++) @(negedge clk_sys_i);
    cmp({15'h0000, busy}, 16'h0000, "busy at end");
    // let the select monitor see the final deselect
    repeat (2) @(negedge clk_sys_i);
    for (k = 0; k < 10; k++) cmp(q_got[k], q_tx[k] & m, "peer word");
    cmp({15'h0000, full_seen}, 16'h0001, "tx refusal");
    if (fmt == FMT_PULSE) cmp(16'(hi_cyc), 16'(2 * h), "pulse width");
    else begin
      cmp(16'(lead_cyc), 16'(cpha ? h : 2 * h), "lead time");
      if (cpha) cmp({15'h0000, rises < 10}, 16'h0001, "select held");
      else cmp(16'(rises), 16'h000A, "select pulses");
    end
    cmp({15'h0000, fss}, {15'h0000, fmt != FMT_PULSE}, "select at end");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp({tx_rdy, rx_vld}, 16'h0002, "fifo reset state");
    @(posedge clk_sys_i);
    en <= 1'b1;
    mst <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    cmp({sclk_oe, fss_oe, busy}, 16'h0000, "slave release");
    @(posedge clk_sys_i);
    mst <= 1'b1;
    for (int i = 0; i < 10; i++) run(i);
    finish_test();
  end
  initial begin
    #900000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
`default_nettype wire
